// ===== ssq_pkg.sv
// ssq_pkg: constants and carrier types for the supply supervisor sequencer
// assumes a 20 MHz core clock; analog comparisons arrive as flags
package ssq_pkg;

    localparam int CLK_HZ = 20000000;
    // sample tick of the internal oscillator, about 30 kHz
    localparam int OSC_HZ = 30000;
    localparam int OSC_DIV = CLK_HZ / OSC_HZ;
    localparam int SAMPLES_TO_TRIP = 3;
    // warning pulse time, least and longest
    localparam int WARN_PULSE_MIN_US = 200;
    localparam int WARN_PULSE_MAX_US = 500;
    localparam int WARN_PULSE_CYC = (WARN_PULSE_MIN_US * (CLK_HZ / 1000000));
    // reset hold time
    localparam int RESET_HOLD_MS = 100;
    localparam int RESET_HOLD_CYC = RESET_HOLD_MS * (CLK_HZ / 1000);
    // watchdog period
    localparam int WDOG_MS = 150;
    localparam int WDOG_CYC = WDOG_MS * (CLK_HZ / 1000);
    // chip-enable hold timeout
    localparam int CE_HOLD_MS = 5000;
    localparam int CE_HOLD_CYC = CE_HOLD_MS * (CLK_HZ / 1000);
    localparam int CNT_W = 32;

    // comparator flags, all active when the comparison is out of tolerance
    typedef struct packed {
        logic below_trip;
        logic below_battery;
        logic warn_below;
    } ssq_flags_t;

    // outputs towards the processor and memory
    typedef struct packed {
        logic reset_hi;
        logic reset_n;
        logic warn_irq_n;
        logic warn_irq_oe_n;
        logic mem_select_out;
        logic supply_switch_flag;
        logic supply_switch_flag_n;
    } ssq_outs_t;

    typedef enum logic [1:0] {
        SSQ_RUN,
        SSQ_SLEEP,
        SSQ_DOWN
    } ssq_state_t;

endpackage

// ===== ssq_supervisor.sv
// ssq_supervisor: reset, warning interrupt, write-protect and power-fail sequencing
// assumes comparator flags and pins are asynchronous and pass a two-stage synchroniser
`timescale 1ns/100ps

// Overview of operation
// - volatile mode: isolate processor signals below battery
// - warning pulse low at most 200 us
// - volatile mode: warning floats below battery level
// - volatile mode: resets active below trip level
// - volatile mode: reset held hold time after valid
// - warning blocked until supply reaches trip
// - pulse ends on timeout or input recovery
// - backed mode: no events until rearm
// - backed mode: no reset on supply fall
// - backed mode: warning pulse then held high
// - backed mode: reset on rise past battery
// - backed mode: warning forces active reset off
// - volatile mode: each kick while low gives another pulse
// - write-protect and power-fail on power-down
// - warning then watchdog reset without kick
// - backed mode: reset when warning input rises
// - sleep disables reset and warning outputs and ignores the warning input
// - button falling edge wakes, watchdog resets
// - wake on control high or power return
// - sleep power loss: reset only volatile mode
// - backed mode: button wake ignores warning input
// - three consecutive low samples start warning
// - static mode pin selects operating mode
// - active chip select held until done
module ssq_supervisor (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // comparator flags and mode
    input wire ssq_pkg::ssq_flags_t flags,
    input wire logic mode_select_pin,
    // processor and memory pins
    input wire logic watchdog_kick_in,
    input wire logic button_reset_in,
    input wire logic wake_sleep_ctl,
    input wire logic mem_select_in,
    // outputs
    output ssq_pkg::ssq_outs_t outs,
    output logic sleeping
);

    localparam int NIN = 8;
    // idle pin levels, so that no false edge follows reset
    localparam logic [NIN-1:0] SYNC_IDLE = 8'h0f;
    logic [NIN-1:0] raw;
    logic [NIN-1:0] sync1;
    logic [NIN-1:0] sync2;
    logic below_trip, below_batt, warn_low, mode_backed, kick, button, wsc, mem_in;
    logic kick_d, button_d, wsc_d, below_batt_d, warn_low_d;
    logic kick_fall, button_fall, wsc_fall, wsc_rise, batt_rise, warn_rise;
    localparam int CNT_W_LOCAL = ssq_pkg::CNT_W;
    logic [CNT_W_LOCAL-1:0] osc_cnt;
    logic osc_tick;
    logic [1:0] low_run;
    logic warn_det;
    logic warn_det_d;
    logic warn_pulse;
    logic [CNT_W_LOCAL-1:0] pulse_cnt;
    logic pulse_done;
    logic rearm_wait;
    logic [CNT_W_LOCAL-1:0] rst_cnt;
    logic rst_act;
    logic [CNT_W_LOCAL-1:0] wdog_cnt;
    logic wdog_armed;
    logic kicked_recent;
    logic [CNT_W_LOCAL-1:0] ce_cnt;
    logic ce_hold;
    logic ce_prot;
    logic ce_take;
    ssq_pkg::ssq_state_t state;
    logic trip_start;
    logic wdog_fire;

    assign raw = {flags.below_trip, flags.below_battery, flags.warn_below, mode_select_pin,
                  watchdog_kick_in, button_reset_in, wake_sleep_ctl, mem_select_in};

    // two-stage synchroniser per input
    generate
        for (genvar i = 0; i < NIN; i++)
        begin : g_sync
            always_ff @(posedge clk)
            begin
                if (srst)
                begin
                    sync1[i] <= SYNC_IDLE[i];
                    sync2[i] <= SYNC_IDLE[i];
                end
                else
                begin
                    sync1[i] <= raw[i];
                    sync2[i] <= sync1[i];
                end
            end
        end
    endgenerate

    assign {below_trip, below_batt, warn_low, mode_backed, kick, button, wsc, mem_in} = sync2;

    // edge history
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            kick_d <= 1'b1;
            button_d <= 1'b1;
            wsc_d <= 1'b1;
            below_batt_d <= 1'b0;
            warn_low_d <= 1'b0;
        end
        else
        begin
            kick_d <= kick;
            button_d <= button;
            wsc_d <= wsc;
            below_batt_d <= below_batt;
            warn_low_d <= warn_low;
        end
    end
    assign kick_fall = kick_d & ~kick;
    assign button_fall = button_d & ~button;
    assign wsc_fall = wsc_d & ~wsc;
    assign wsc_rise = ~wsc_d & wsc;
    assign batt_rise = below_batt_d & ~below_batt;
    assign warn_rise = warn_low_d & ~warn_low;

    // operating state: run, sleep, unpowered
    always_ff @(posedge clk)
    begin
        if (srst)
            state <= ssq_pkg::SSQ_RUN;
        else
        begin
            case (state)
                ssq_pkg::SSQ_RUN:
                    if (below_batt)
                        state <= ssq_pkg::SSQ_DOWN;
                    else if (wsc_fall && kicked_recent)
                        state <= ssq_pkg::SSQ_SLEEP;
                ssq_pkg::SSQ_SLEEP:
                    if (button_fall || wsc_rise)
                        state <= ssq_pkg::SSQ_RUN;
                    else if (below_batt)
                        state <= ssq_pkg::SSQ_DOWN;
                ssq_pkg::SSQ_DOWN:
                    if (!below_batt)
                        state <= ssq_pkg::SSQ_RUN;
                default:
                    state <= ssq_pkg::SSQ_RUN;
            endcase
        end
    end
    assign sleeping = (state == ssq_pkg::SSQ_SLEEP);

    // kick seen since the state last returned to run
    always_ff @(posedge clk)
    begin
        if (srst)
            kicked_recent <= 1'b0;
        else if (kick_fall)
            kicked_recent <= 1'b1;
        else if (state != ssq_pkg::SSQ_RUN)
            kicked_recent <= 1'b0;
    end

    // sample tick from the internal oscillator
    always_ff @(posedge clk)
    begin
        if (srst || osc_tick)
            osc_cnt <= '0;
        else
            osc_cnt <= osc_cnt + 1'b1;
    end
    assign osc_tick = (osc_cnt == CNT_W_LOCAL'(ssq_pkg::OSC_DIV - 1));

    // three consecutive low samples, else the detection clears
    always_ff @(posedge clk)
    begin
        if (srst || state != ssq_pkg::SSQ_RUN || below_trip && !warn_det)
        begin
            low_run <= '0;
            warn_det <= 1'b0;
        end
        else if (osc_tick)
        begin
            if (!warn_low)
            begin
                low_run <= '0;
                warn_det <= 1'b0;
            end
            else if (low_run == 2'(ssq_pkg::SAMPLES_TO_TRIP - 1))
                warn_det <= 1'b1;
            else
                low_run <= low_run + 1'b1;
        end
    end
    always_ff @(posedge clk)
    begin
        if (srst)
            warn_det_d <= 1'b0;
        else
            warn_det_d <= warn_det;
    end
    assign trip_start = (warn_det && !warn_det_d) || (warn_det && kick_fall);

    // warning pulse timing
    assign pulse_done = (pulse_cnt == CNT_W_LOCAL'(ssq_pkg::WARN_PULSE_CYC - 1));
    always_ff @(posedge clk)
    begin
        if (srst || state != ssq_pkg::SSQ_RUN)
        begin
            warn_pulse <= 1'b0;
            pulse_cnt <= '0;
        end
        else if (warn_pulse)
        begin
            if (pulse_done || !warn_low)
                warn_pulse <= 1'b0;
            pulse_cnt <= pulse_cnt + 1'b1;
        end
        else if (trip_start && !(mode_backed && rearm_wait))
        begin
            warn_pulse <= 1'b1;
            pulse_cnt <= '0;
        end
    end

    // backed mode quiet period after a pulse
    always_ff @(posedge clk)
    begin
        if (srst || warn_rise || batt_rise)
            rearm_wait <= 1'b0;
        else if (warn_pulse && (pulse_done || !warn_low) && mode_backed && !kick_fall)
            rearm_wait <= 1'b1;
    end

    // watchdog, armed when the warning input rises, on a button fall, or in run in volatile mode
    always_ff @(posedge clk)
    begin
        if (srst || state == ssq_pkg::SSQ_DOWN)
            wdog_armed <= 1'b0;
        else if (warn_rise || button_fall || (state == ssq_pkg::SSQ_RUN && !mode_backed))
            wdog_armed <= 1'b1;
    end
    always_ff @(posedge clk)
    begin
        if (srst || kick_fall || rst_act || state == ssq_pkg::SSQ_DOWN)
            wdog_cnt <= '0;
        else if (wdog_armed && (state == ssq_pkg::SSQ_RUN || button_fall) && !wdog_fire)
            wdog_cnt <= wdog_cnt + 1'b1;
        else if (wdog_fire)
            wdog_cnt <= '0;
    end
    assign wdog_fire = (wdog_cnt == CNT_W_LOCAL'(ssq_pkg::WDOG_CYC - 1));

    // reset sequencing
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rst_act <= 1'b1;
            rst_cnt <= '0;
        end
        else if (!mode_backed && (below_trip || state == ssq_pkg::SSQ_DOWN))
        begin
            rst_act <= 1'b1;
            rst_cnt <= '0;
        end
        else if (mode_backed && (below_batt || (state == ssq_pkg::SSQ_SLEEP)))
        begin
            rst_act <= 1'b0;
            rst_cnt <= '0;
        end
        else if (mode_backed && (batt_rise || (warn_rise && rearm_wait)))
        begin
            rst_act <= 1'b1;
            rst_cnt <= '0;
        end
        else if (mode_backed && rst_act && warn_pulse)
            rst_act <= 1'b0;
        else if (wdog_fire)
        begin
            rst_act <= 1'b1;
            rst_cnt <= '0;
        end
        else if (rst_act)
        begin
            if (rst_cnt == CNT_W_LOCAL'(ssq_pkg::RESET_HOLD_CYC - 1))
                rst_act <= 1'b0;
            else
                rst_cnt <= rst_cnt + 1'b1;
        end
    end

    // chip-select write protect with hold of an active cycle
    assign ce_prot = below_trip || state == ssq_pkg::SSQ_DOWN;
    // an active cycle at the moment of failure is held from its first cycle on
    assign ce_take = !ce_hold && ce_cnt == '0 && !mem_in;
    always_ff @(posedge clk)
    begin
        if (srst || !ce_prot)
        begin
            ce_hold <= 1'b0;
            ce_cnt <= '0;
        end
        else if (ce_take)
        begin
            ce_hold <= 1'b1;
            ce_cnt <= ce_cnt + 1'b1;
        end
        else if (ce_hold)
        begin
            if (mem_in || ce_cnt == CNT_W_LOCAL'(ssq_pkg::CE_HOLD_CYC - 1))
                ce_hold <= 1'b0;
            ce_cnt <= ce_cnt + 1'b1;
        end
        else
            ce_cnt <= ce_cnt | CNT_W_LOCAL'(1);
    end

    // output register
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            outs.reset_hi <= 1'b1;
            outs.reset_n <= 1'b0;
            outs.warn_irq_n <= 1'b1;
            outs.warn_irq_oe_n <= 1'b0;
            outs.mem_select_out <= 1'b1;
            outs.supply_switch_flag <= 1'b0;
            outs.supply_switch_flag_n <= 1'b1;
        end
        else
        begin
            outs.reset_hi <= rst_act && !(state == ssq_pkg::SSQ_SLEEP);
            outs.reset_n <= !(rst_act && !(state == ssq_pkg::SSQ_SLEEP));
            outs.warn_irq_n <= !(warn_pulse && state == ssq_pkg::SSQ_RUN);
            outs.warn_irq_oe_n <= !mode_backed && below_batt;
            outs.mem_select_out <= (ce_prot && !ce_hold && !ce_take) ? 1'b1 : mem_in;
            outs.supply_switch_flag <= below_batt;
            outs.supply_switch_flag_n <= !below_batt;
        end
    end

endmodule

// ===== ssq_supervisor_properties.sv
// ssq_supervisor_properties: timing checks on the supervisor ports
// assumes it is bound to ssq_supervisor, one clock domain
`timescale 1ns/100ps
module ssq_supervisor_properties (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // inputs
    input wire ssq_pkg::ssq_flags_t flags,
    input wire logic mode_select_pin,
    input wire logic mem_select_in,
    // outputs
    input wire ssq_pkg::ssq_outs_t outs,
    input wire logic sleeping
);
    localparam int PULSE = ssq_pkg::WARN_PULSE_CYC;
    localparam int FILT = 2 * ssq_pkg::OSC_DIV;
    localparam int PMAX = ssq_pkg::WARN_PULSE_MAX_US * 20;
    int lo_cnt;
    int hi_cnt;
    // length of the driven low warning level
    always_ff @(posedge clk)
    begin
        lo_cnt <= (srst || outs.warn_irq_n || outs.warn_irq_oe_n) ? 0 : lo_cnt + 1;
    end
    always_ff @(posedge clk)
    begin
        hi_cnt <= (srst || !flags.warn_below) ? 0 : hi_cnt + 1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_pulse_end;
        $rose(outs.warn_irq_n) && hi_cnt > lo_cnt + 8;
    endsequence
    a_reset_pair: assert property (outs.reset_hi == !outs.reset_n)
        else $error("reset outputs disagree");
    a_pulse_len: assert property (s_pulse_end |-> lo_cnt >= PULSE - 2 && lo_cnt <= PULSE + 2)
        else $error("warning pulse length wrong");
    a_pulse_max: assert property (lo_cnt <= PMAX)
        else $error("warning pulse too long");
    a_sample_filter: assert property ($fell(outs.warn_irq_n) |-> hi_cnt >= FILT)
        else $error("warning without three samples");
    a_trip_reset: assert property ((!mode_select_pin && flags.below_trip) [*6] |-> outs.reset_hi)
        else $error("no reset below trip");
    a_backed_no_reset: assert property (mode_select_pin && outs.reset_n && flags.below_trip |=> outs.reset_n)
        else $error("reset on supply fall");
    a_float_warn: assert property ((!mode_select_pin && flags.below_battery) [*6] |-> outs.warn_irq_oe_n)
        else $error("warning pin still driven");
    a_switch_set: assert property (flags.below_battery [*6] |-> outs.supply_switch_flag && !outs.supply_switch_flag_n)
        else $error("power-fail not raised");
    a_switch_clear: assert property ((!flags.below_battery) [*6] |-> !outs.supply_switch_flag)
        else $error("power-fail not cleared");
    a_mem_protect: assert property ((flags.below_trip && mem_select_in) [*6] |-> outs.mem_select_out)
        else $error("memory not protected");
    a_sleep_quiet: assert property (sleeping && mode_select_pin |=> outs.reset_n && outs.warn_irq_n)
        else $error("output active in sleep");
endmodule

// ===== ssq_cpu_model.sv
// ssq_cpu_model: processor side, kicks the watchdog, requests sleep and wake
// assumes its tasks are called just after a rising clock edge
`timescale 1ns/100ps
module ssq_cpu_model (
    // clock
    input wire logic clk,
    // pins towards the supervisor
    output logic watchdog_kick_in,
    output logic wake_sleep_ctl,
    output logic button_reset_in
);
    // sleep setup time in cycles, plain value
    localparam int SETUP_CYC = 8;
    initial
    begin
        watchdog_kick_in = 1'b1;
        wake_sleep_ctl = 1'b1;
        button_reset_in = 1'b1;
    end
    task automatic go_sleep();
        watchdog_kick_in = 1'b0;
        repeat (4) @(posedge clk);
        #5 watchdog_kick_in = 1'b1;
        repeat (SETUP_CYC) @(posedge clk);
        #5 wake_sleep_ctl = 1'b0;
    endtask
    task automatic kick();
        watchdog_kick_in = 1'b0;
        repeat (4) @(posedge clk);
        #5 watchdog_kick_in = 1'b1;
    endtask
    task automatic wake(input logic by_button);
        if (by_button)
        begin
            button_reset_in = 1'b0;
            repeat (4) @(posedge clk);
            #5 button_reset_in = 1'b1;
            repeat (20) @(posedge clk);
            #5;
        end
        wake_sleep_ctl = 1'b1;
    endtask
endmodule

// ===== ssq_supervisor_tb.sv
// ssq_supervisor_tb: directed tests of warning, power and sleep sequencing
// assumes ssq_pkg, ssq_supervisor, ssq_cpu_model and the property checker
`timescale 1ns/100ps
module ssq_supervisor_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    ssq_pkg::ssq_flags_t flags = '0;
    logic mode_select_pin = 1'b1;
    logic mem_select_in = 1'b1;
    logic watchdog_kick_in;
    logic wake_sleep_ctl;
    logic button_reset_in;
    ssq_pkg::ssq_outs_t outs;
    logic sleeping;
    int mismatches = 0;
    int n_compared = 0;
    int n;
    always #25 clk = ~clk;
    ssq_supervisor u_dut (.clk(clk), .srst(srst), .flags(flags), .mode_select_pin(mode_select_pin),
        .watchdog_kick_in(watchdog_kick_in), .button_reset_in(button_reset_in),
        .wake_sleep_ctl(wake_sleep_ctl), .mem_select_in(mem_select_in), .outs(outs), .sleeping(sleeping));
    ssq_cpu_model u_cpu (.clk(clk), .watchdog_kick_in(watchdog_kick_in), .wake_sleep_ctl(wake_sleep_ctl),
        .button_reset_in(button_reset_in));
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #5;
    endtask
    task automatic chk(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask
    task automatic stop_test();
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wait_irq(input logic v, input int bound, output int k);
        k = 0;
        while (outs.warn_irq_n !== v && k < bound)
        begin
            step(1);
            k++;
        end
        if (k >= bound)
        begin
            mismatches++;
            $display("[ERR] %0t wait timed out", $time);
            stop_test();
        end
    endtask
    // warning must stay high for k cycles
    task automatic quiet_irq(input int k, input string what);
        logic low;
        low = 1'b0;
        repeat (k)
        begin
            step(1);
            if (outs.warn_irq_n !== 1'b1)
                low = 1'b1;
        end
        chk(low, 1'b0, what);
    endtask
    task automatic do_reset(input logic mode);
        mode_select_pin = mode;
        srst = 1'b1;
        step(8);
        srst = 1'b0;
        step(4);
    endtask
    initial
    begin
        do_reset(1'b1);
        chk(outs.reset_hi, 1'b1, "no reset after start");
        flags.warn_below = 1'b1;
        wait_irq(1'b0, 3000, n);
        step(4);
        chk(outs.reset_n, 1'b1, "warning left reset active");
        wait_irq(1'b1, 6000, n);
        chk(n >= ssq_pkg::WARN_PULSE_CYC - 8 && n <= ssq_pkg::WARN_PULSE_CYC, 1'b1, "pulse length");
        u_cpu.kick();
        quiet_irq(6000, "pulse without rearm");
        flags.warn_below = 1'b0;
        step(10);
        chk(outs.reset_hi, 1'b1, "no reset on warning rise");
        flags.warn_below = 1'b1;
        step(600);
        flags.warn_below = 1'b0;
        quiet_irq(3000, "short dip gave warning");
        $display("test warning done");
        for (int w = 0; w < 2; w++)
        begin
            u_cpu.go_sleep();
            step(6);
            chk(sleeping, 1'b1, "sleep not entered");
            flags.warn_below = 1'b1;
            quiet_irq(3000, "warning in sleep");
            flags.warn_below = 1'b0;
            u_cpu.wake(w == 0);
            step(6);
            chk(sleeping, 1'b0, "no wake");
        end
        $display("test sleep done");
        mem_select_in = 1'b0;
        flags.below_trip = 1'b1;
        step(10);
        chk(outs.mem_select_out, 1'b0, "active memory cycle cut");
        mem_select_in = 1'b1;
        step(10);
        chk(outs.mem_select_out, 1'b1, "memory not protected");
        chk(outs.reset_n, 1'b1, "reset on supply fall");
        flags.below_battery = 1'b1;
        step(10);
        chk(outs.supply_switch_flag, 1'b1, "power-fail not set");
        chk(outs.supply_switch_flag_n, 1'b0, "power-fail low not set");
        flags = '0;
        step(10);
        chk(outs.supply_switch_flag, 1'b0, "power-fail not cleared");
        chk(outs.reset_hi, 1'b1, "no reset on power return");
        $display("test backed power done");
        do_reset(1'b0);
        step(1000);
        chk(outs.reset_hi, 1'b1, "reset released early");
        flags.below_trip = 1'b1;
        flags.below_battery = 1'b1;
        step(10);
        chk(outs.warn_irq_oe_n, 1'b1, "warning still driven");
        chk(outs.reset_n, 1'b0, "no reset below trip");
        $display("test volatile power done");
        stop_test();
    end
    initial
    begin
        #5000000;
        mismatches++;
        $display("[ERR] %0t run timed out", $time);
        stop_test();
    end
endmodule
bind ssq_supervisor ssq_supervisor_properties u_props (.clk(clk), .srst(srst), .flags(flags),
    .mode_select_pin(mode_select_pin), .mem_select_in(mem_select_in), .outs(outs), .sleeping(sleeping));
